// ==== tcu_map.vh ====
/*
 * Register map, field positions, mode codes and reset values for the
 * timer compare unit. Assumes plain Verilog-2005 inclusion by bare name.
 */
`ifndef TCU_MAP_VH
`define TCU_MAP_VH

// Word byte addresses on the Avalon-MM slave
`define TCU_ADDR_CTRL      4'h0
`define TCU_ADDR_CMPVAL    4'h4
`define TCU_ADDR_TIMER     4'h8
`define TCU_ADDR_STATUS    4'hc
`define TCU_ADDR_W         4

// Control register fields
`define TCU_MODE_LSB       0
`define TCU_MODE_MSB       3
`define TCU_CONV_EN_BIT    4
`define TCU_TMR_ON_BIT     5

// Status register fields (match and overflow bits write one to clear)
`define TCU_ST_MATCH_BIT   0
`define TCU_ST_OVF_BIT     1
`define TCU_ST_PIN_BIT     2
`define TCU_ST_OE_BIT      3

// Compare mode codes
`define TCU_MODE_OFF       4'h0
`define TCU_MODE_TOGGLE    4'h2
`define TCU_MODE_SET       4'h8
`define TCU_MODE_CLEAR     4'h9
`define TCU_MODE_SWINT     4'ha
`define TCU_MODE_SPECIAL   4'hb

// Reset values
`define TCU_CTRL_RST       6'h00
`define TCU_CMPVAL_RST     16'hffff
`define TCU_TIMER_RST      16'h0000

`endif

// ==== tcu_timer.v ====
/*
 * Free-running 16-bit timer counting on a one-cycle tick, with software
 * load, a clear request from the special event trigger and an overflow
 * pulse. Assumes the tick is synchronous to clk_i.
 */
module tcu_timer #(
    parameter WIDTH = 16
) (
    input  wire             clk_i,
    input  wire             rst_b_i,
    input  wire             tick_i,
    input  wire             clear_i,
    input  wire             load_i,
    input  wire [WIDTH-1:0] load_val_i,
    output reg  [WIDTH-1:0] count_o,
    output reg              ovf_o
);

    // Clear takes effect on the tick edge only; load wins over both
    always @(posedge clk_i) begin
        if (!rst_b_i) begin
            count_o <= {WIDTH{1'b0}};
            ovf_o   <= 1'b0;
        end else if (load_i) begin
            count_o <= load_val_i;
            ovf_o   <= 1'b0;
        end else if (tick_i) begin
            if (clear_i) begin
                count_o <= {WIDTH{1'b0}};
                ovf_o   <= 1'b0;                 // [RULE_11]
            end else begin
                count_o <= count_o + {{(WIDTH-1){1'b0}}, 1'b1};
                ovf_o   <= &count_o;
            end
        end else begin
            ovf_o <= 1'b0;
        end
    end

endmodule // tcu_timer

// ==== tcu_compare.v ====
/*
 * Compare unit: register file on Avalon-MM, timer instance, match logic,
 * pin action and special event trigger. Assumes the bus master holds a
 * request until waitrequest is sampled low, and that the timer tick comes
 * from a divided clock or a synchronised external source.
 */
`include "tcu_map.vh"

// Overview of operation
// [RULE_01] Compare value is checked against timer count continuously; equality is a match.
// [RULE_02] A match performs one selected action: toggle, set, clear, trigger or interrupt.
// [RULE_03] Pin action follows mode field; match flag sets together with the action.
// [RULE_04] Software sets the pin as output before relying on the compare pin.
// [RULE_05] Writing zero to the whole control register forces the compare latch low.
// [RULE_06] The timer must run synchronously while compare mode is used.
// [RULE_07] The timer must be ticked from a divided or external clock, not undivided.
// [RULE_08] Mode 1010 only raises the match flag and leaves the pin alone.
// [RULE_09] Mode 1011 resets the timer, starts conversion if enabled, pin uncontrolled.
// [RULE_10] Trigger asserts at match; timer clears on the next timer tick.
// [RULE_11] A trigger-caused timer reset never sets the timer overflow flag.
// [RULE_12] If the match vanishes before the reset edge, no timer reset occurs.
// [RULE_13] Toggle, set and clear codes are 0010, 1000 and 1001.
module tcu_compare #(
    parameter WIDTH = 16
) (
    input  wire                   clk_i,
    input  wire                   rst_b_i,
    input  wire                   tick_i,
    input  wire [`TCU_ADDR_W-1:0] avs_address_i,
    input  wire                   avs_read_i,
    input  wire                   avs_write_i,
    input  wire [31:0]            avs_writedata_i,
    input  wire [3:0]             avs_byteenable_i,
    output reg  [31:0]            avs_readdata_o,
    output reg                    avs_waitrequest_o,
    output reg                    cmp_pin_o,
    output reg                    cmp_pin_oe_o,
    output reg                    special_trig_o,
    output reg                    conv_start_o,
    output reg                    match_flag_o
);

    reg  [5:0]       ctrl;
    reg  [WIDTH-1:0] cmp_val;
    reg              cmp_latch;
    reg              match_flag;
    reg              ovf_flag;
    reg              match_d;
    reg              acc_done;
    wire [WIDTH-1:0] tmr_count;
    wire             tmr_ovf;
    wire [3:0]       mode;
    wire             match;
    wire             match_rise;
    wire             tmr_clear;
    wire             tmr_load;
    wire             pin_mode;
    wire             acc;
    wire             wr_ctrl;
    wire             wr_cmp;
    wire             wr_stat;
    reg  [31:0]      next_rdata;
    reg              next_latch;

    assign mode       = ctrl[`TCU_MODE_MSB:`TCU_MODE_LSB];
    // Equality is evaluated every cycle, not only on ticks
    assign match      = (cmp_val == tmr_count) && (mode != `TCU_MODE_OFF); // [RULE_01]
    // Act once per match, not every cycle the count rests on the value
    assign match_rise = match && !match_d;
    // Live match gates the clear so a moved compare value cancels it
    assign tmr_clear  = (mode == `TCU_MODE_SPECIAL) && match;    // [RULE_10] [RULE_12]
    assign pin_mode   = (mode == `TCU_MODE_TOGGLE) || (mode == `TCU_MODE_SET) ||
                        (mode == `TCU_MODE_CLEAR);              // [RULE_08] [RULE_09]

    // Bus decode: one wait cycle, answer on the second edge
    assign acc      = (avs_read_i || avs_write_i) && !acc_done;
    assign wr_ctrl  = acc && avs_write_i && (avs_address_i == `TCU_ADDR_CTRL) &&
                      avs_byteenable_i[0];
    assign wr_cmp   = acc && avs_write_i && (avs_address_i == `TCU_ADDR_CMPVAL);
    assign tmr_load = acc && avs_write_i && (avs_address_i == `TCU_ADDR_TIMER);
    assign wr_stat  = acc && avs_write_i && (avs_address_i == `TCU_ADDR_STATUS) &&
                      avs_byteenable_i[0];

    tcu_timer #(
        .WIDTH      (WIDTH)
    ) u_timer (
        .clk_i      (clk_i),
        .rst_b_i    (rst_b_i),
        .tick_i     (tick_i),
        .clear_i    (tmr_clear),
        .load_i     (tmr_load),
        .load_val_i (avs_writedata_i[WIDTH-1:0]),
        .count_o    (tmr_count),
        .ovf_o      (tmr_ovf)
    );

    // Compare latch next value
    always @* begin
        next_latch = cmp_latch;
        if (match_rise) begin
            case (mode)                                        // [RULE_02] [RULE_13]
                `TCU_MODE_TOGGLE: next_latch = ~cmp_latch;
                `TCU_MODE_SET:    next_latch = 1'b1;
                `TCU_MODE_CLEAR:  next_latch = 1'b0;
                default:          next_latch = cmp_latch;
            endcase
        end
        if (wr_ctrl && avs_writedata_i[5:0] == 6'h00) begin
            next_latch = 1'b0;                                 // [RULE_05]
        end
    end

    // Read mux
    always @* begin
        next_rdata = 32'h0000_0000;
        case (avs_address_i)
            `TCU_ADDR_CTRL:   next_rdata[5:0] = ctrl;
            `TCU_ADDR_CMPVAL: next_rdata[WIDTH-1:0] = cmp_val;
            `TCU_ADDR_TIMER:  next_rdata[WIDTH-1:0] = tmr_count;
            `TCU_ADDR_STATUS: next_rdata[3:0] = {cmp_pin_oe_o, cmp_latch, ovf_flag,
                                                 match_flag};
            default:          next_rdata = 32'h0000_0000;
        endcase
    end

    // Registers, flags and bus handshake
    always @(posedge clk_i) begin
        if (!rst_b_i) begin
            ctrl              <= `TCU_CTRL_RST;
            cmp_val           <= `TCU_CMPVAL_RST;
            cmp_latch         <= 1'b0;
            match_flag        <= 1'b0;
            ovf_flag          <= 1'b0;
            match_d           <= 1'b0;
            acc_done          <= 1'b0;
            avs_readdata_o    <= 32'h0000_0000;
            avs_waitrequest_o <= 1'b1;
        end else begin
            match_d   <= match;
            cmp_latch <= next_latch;
            acc_done  <= acc;
            avs_waitrequest_o <= !acc;
            if (acc) begin
                avs_readdata_o <= next_rdata;
            end
            if (wr_ctrl) begin
                ctrl <= avs_writedata_i[5:0];
            end
            // Byte lanes of the 16-bit compare value
            if (wr_cmp && avs_byteenable_i[0]) begin
                cmp_val[7:0] <= avs_writedata_i[7:0];
            end
            if (wr_cmp && avs_byteenable_i[1]) begin
                cmp_val[15:8] <= avs_writedata_i[15:8];
            end
            // Set wins over a write-one clear in the same cycle
            if (match_rise) begin
                match_flag <= 1'b1;                            // [RULE_03] [RULE_08]
            end else if (wr_stat && avs_writedata_i[`TCU_ST_MATCH_BIT]) begin
                match_flag <= 1'b0;
            end
            if (tmr_ovf) begin
                ovf_flag <= 1'b1;                              // [RULE_11]
            end else if (wr_stat && avs_writedata_i[`TCU_ST_OVF_BIT]) begin
                ovf_flag <= 1'b0;
            end
        end
    end

    // Outputs registered; trigger follows the match level directly
    always @(posedge clk_i) begin
        if (!rst_b_i) begin
            cmp_pin_o      <= 1'b0;
            cmp_pin_oe_o   <= 1'b0;
            special_trig_o <= 1'b0;
            conv_start_o   <= 1'b0;
            match_flag_o   <= 1'b0;
        end else begin
            cmp_pin_o      <= next_latch;
            cmp_pin_oe_o   <= pin_mode;                        // [RULE_08] [RULE_09]
            special_trig_o <= tmr_clear;                       // [RULE_10]
            conv_start_o   <= match_rise && (mode == `TCU_MODE_SPECIAL) &&
                              ctrl[`TCU_CONV_EN_BIT];          // [RULE_09]
            match_flag_o   <= match_rise | (match_flag &
                              !(wr_stat && avs_writedata_i[`TCU_ST_MATCH_BIT]));
        end
    end

endmodule // tcu_compare

// ==== tcu_far_model.sv ====
/* Timer tick source and converter start counter.
   Assumes one clock and a sync active-low reset. */
module tcu_far_model (
    input  wire        clk_i,
    input  wire        rst_b_i,
    input  wire        en_i,
    input  wire        conv_start_i,
    output logic       tick_o,
    output logic [7:0] conv_cnt_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] div;
    // Tick at a quarter rate, never the undivided clock
    always @(posedge clk_i) begin
        if (!rst_b_i) begin
            div <= 2'h0;
            tick_o <= 1'b0;
            conv_cnt_o <= 8'h00;
        end else begin
            div <= div + 2'h1;
            tick_o <= en_i && div == 2'h3;
            if (conv_start_i)
                conv_cnt_o <= conv_cnt_o + 8'h01;
        end
    end
endmodule // tcu_far_model

// ==== tcu_monitor.sv ====
/* Port checker for the compare unit.
   Assumes one clock domain and sync active-low reset. */
module tcu_monitor (
    input wire clk_i,
    input wire rst_b_i,
    input wire avs_read_i,
    input wire avs_write_i,
    input wire avs_waitrequest_o,
    input wire cmp_pin_oe_o,
    input wire special_trig_o,
    input wire conv_start_o,
    input wire match_flag_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    sequence ack_s; !avs_waitrequest_o; endsequence
    sequence trig_s; $rose(special_trig_o); endsequence
    // Bus answers and trigger behaviour
    wait_one_a: assert property (ack_s |=> avs_waitrequest_o) else $error("ack too long");
    wait_cause_a: assert property (ack_s |-> $past(avs_read_i) || $past(avs_write_i))
        else $error("ack without request");
    conv_pulse_a: assert property (conv_start_o |=> !conv_start_o) else $error("conv long");
    conv_trig_a: assert property (conv_start_o |-> special_trig_o) else $error("conv alone");
    trig_pin_a: assert property (special_trig_o |-> !cmp_pin_oe_o) else $error("pin driven");
    trig_flag_a: assert property (trig_s |-> match_flag_o) else $error("flag late");
    trig_end_a: assert property (trig_s |-> ##[1:40] !special_trig_o) else $error("stuck");
    oe_write_a: assert property ($changed(cmp_pin_oe_o) |-> $past(avs_write_i)
        || $past(avs_write_i, 2)) else $error("oe moved alone");
    flag_clr_a: assert property ($fell(match_flag_o) |-> $past(avs_write_i)
        || $past(avs_write_i, 2)) else $error("flag lost");
endmodule // tcu_monitor
bind tcu_compare tcu_monitor i_mon (.clk_i, .rst_b_i, .avs_read_i, .avs_write_i,
    .avs_waitrequest_o, .cmp_pin_oe_o, .special_trig_o, .conv_start_o, .match_flag_o);

// ==== testbench.sv ====
/* Self-checking bench for the compare unit.
   Assumes the far model supplies ticks and counts conversion starts. */
`include "tcu_map.vh"
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_i = 0, rst_b_i = 0, tick_en = 0, avs_read_i = 0, avs_write_i = 0;
    logic [3:0]  avs_address_i = 4'h0, avs_byteenable_i = 4'hf;
    logic [31:0] avs_writedata_i = 32'h0, exp_q[$], msk_q[$];
    wire [31:0] avs_readdata_o;
    wire avs_waitrequest_o, cmp_pin_o, cmp_pin_oe_o, special_trig_o, conv_start_o;
    wire match_flag_o, tick_i;
    wire [7:0] conv_cnt;
    int errors = 0, checks = 0;
    logic [7:0]  lf = 8'h4a;
    logic [15:0] v;
    logic [3:0]  md[4] = '{4'h8, 4'h2, 4'h9, 4'ha};
    logic        pe[4] = '{1, 1, 0, 0};
    always #25 clk_i = ~clk_i;
    tcu_compare i_dut (.clk_i, .rst_b_i, .tick_i, .avs_address_i, .avs_read_i, .avs_write_i,
        .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o,
        .cmp_pin_o, .cmp_pin_oe_o, .special_trig_o, .conv_start_o, .match_flag_o);
    tcu_far_model i_far (.clk_i, .rst_b_i, .en_i(tick_en), .conv_start_i(conv_start_o),
        .tick_o(tick_i), .conv_cnt_o(conv_cnt));
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            errors++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    // Hold the request until waitrequest is sampled low
    task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        avs_address_i <= a;
        avs_writedata_i <= d;
        avs_write_i <= w;
        avs_read_i <= !w;
        do begin
            @(posedge clk_i);
            n++;
        end while (avs_waitrequest_o !== 1'b0 && n < 50);
        if (n >= 50) errors++;
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
    endtask
    task rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
        exp_q.push_back(e & m);
        msk_q.push_back(m);
        bus(1'b0, a, 32'h0);
    endtask
    // Bounded wait: 0 flag high, 1 trigger high, 2 trigger low
    task wt(input logic [1:0] k);
        int n;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (!(k == 0 ? match_flag_o === 1'b1 : special_trig_o === (k == 1)) && n < 100);
        if (n >= 100) errors++;
    endtask
    task final_report;
        $display("errors %0d checks %0d", errors, checks);
        if (errors == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // Read results taken off the queue as they appear
    always @(posedge clk_i) begin
        if (avs_read_i && avs_waitrequest_o === 1'b0 && exp_q.size() > 0) begin
            chk("readdata", exp_q.pop_front(), avs_readdata_o & msk_q.pop_front());
        end
    end
    initial begin
        #1000000;
        errors++;
        final_report;
    end
    initial begin
        repeat (16) @(posedge clk_i);
        rst_b_i <= 1'b1;
        rd(`TCU_ADDR_CTRL, 32'h0, 32'hffffffff);
        rd(`TCU_ADDR_CMPVAL, 32'hffff, 32'hffffffff);
        rd(`TCU_ADDR_TIMER, 32'h0, 32'hffffffff);
        rd(4'h6, 32'h0, 32'hffffffff);
        tick_en <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            bus(1'b1, `TCU_ADDR_CTRL, 32'h0);
            @(posedge clk_i);
            chk("latch", 32'h0, cmp_pin_o);
            lf = lfsr(lf);
            v = {1'b1, lf[6:0], 8'h40};
            bus(1'b1, `TCU_ADDR_CMPVAL, v);
            bus(1'b1, `TCU_ADDR_CTRL, md[i]);
            bus(1'b1, `TCU_ADDR_TIMER, v - 16'h3);
            wt(2'h0);
            chk("pin", pe[i], cmp_pin_o);
            chk("oe", i < 3, cmp_pin_oe_o);
            bus(1'b1, `TCU_ADDR_STATUS, 32'h1);
            @(posedge clk_i);
            chk("flag", 32'h0, match_flag_o);
        end
        // Trigger with the timer held still between ticks
        tick_en <= 1'b0;
        lf = lfsr(lf);
        v = {1'b1, lf[6:0], 8'h40};
        bus(1'b1, `TCU_ADDR_CMPVAL, v);
        // Mode first, so the match edge itself falls in trigger mode
        bus(1'b1, `TCU_ADDR_CTRL, 32'h1b);
        bus(1'b1, `TCU_ADDR_TIMER, v);
        wt(2'h1);
        repeat (2) @(posedge clk_i);
        chk("conv", 32'h1, conv_cnt);
        rd(`TCU_ADDR_TIMER, v, 32'hffff);
        bus(1'b1, `TCU_ADDR_CMPVAL, v + 16'h8);
        tick_en <= 1'b1;
        repeat (8) @(posedge clk_i);
        tick_en <= 1'b0;
        rd(`TCU_ADDR_TIMER, v, 32'hff00);
        bus(1'b1, `TCU_ADDR_TIMER, v + 16'h8);
        wt(2'h1);
        tick_en <= 1'b1;
        wt(2'h2);
        tick_en <= 1'b0;
        rd(`TCU_ADDR_TIMER, 32'h0, 32'hff00);
        rd(`TCU_ADDR_STATUS, 32'h0, 32'h2);
        chk("conv", 32'h2, conv_cnt);
        final_report;
    end
endmodule // testbench
